// File: include/adc_ctrl_pkg.sv
// Constants, register map and field layout of the converter control block.
// Assumes a single 40 MHz clock shared by all users of the package.
package adc_ctrl_pkg;
  // ==========================================================================
  // Sizes
  localparam int NUM_CH = 4;
  localparam int CH_W   = 2;
  localparam int RAW_W  = 12;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;
  localparam int LAT_W  = 8;
  // ==========================================================================
  // Timing, in ns as specified, then in cycles
  localparam int CLK_MHZ  = 40;
  localparam int LAT12_NS = 3500;
  localparam int LAT8_NS  = 2500;
  localparam int SMP_NS   = 500;
  localparam int SWEEP_NS = 1500;
  localparam int LAT12_CYC = (LAT12_NS * CLK_MHZ + 999) / 1000;
  localparam int LAT8_CYC  = (LAT8_NS * CLK_MHZ + 999) / 1000;
  localparam int SMP_CYC   = (SMP_NS * CLK_MHZ + 999) / 1000;
  localparam int SWEEP_CYC = (SWEEP_NS * CLK_MHZ) / 1000;
  // ==========================================================================
  // Register offsets
  localparam logic [ADDR_W-1:0] A_CTRL  = 4'h0;
  localparam logic [ADDR_W-1:0] A_START = 4'h1;
  localparam logic [ADDR_W-1:0] A_EVSEL = 4'h2;
  localparam logic [ADDR_W-1:0] A_STAT  = 4'h3;
  localparam logic [ADDR_W-1:0] A_MASK  = 4'h4;
  localparam logic [ADDR_W-1:0] A_CMPV  = 4'h5;
  localparam logic [ADDR_W-1:0] A_CMPC  = 4'h6;
  localparam logic [ADDR_W-1:0] A_MUX0  = 4'h8;
  localparam logic [ADDR_W-1:0] A_RES0  = 4'hC;
  // ==========================================================================
  // Control bits
  localparam int B_EN    = 0;
  localparam int B_RES8  = 1;
  localparam int B_SGN   = 2;
  localparam int B_LEFT  = 3;
  localparam int B_PAD1  = 4;
  localparam int B_REFX  = 5;
  localparam int B_DMA   = 6;
  localparam int B_EVEN  = 7;
  localparam int B_SYNC  = 8;
  localparam int CTRL_W  = 9;
  // Channel input selection fields
  localparam int M_POS_LO = 0;
  localparam int M_DIFF   = 4;
  localparam int M_NEG_LO = 5;
  localparam int M_GN_LO  = 7;
  localparam int MUX_W    = 10;
  localparam logic [3:0] POS_MAX  = 4'hB;
  localparam logic [2:0] GAIN_MAX = 3'h6;
  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;
  localparam logic [MUX_W-1:0]  MUX_RST  = 10'h000;
endpackage

// File: include/conv_if.sv
// Link between the issue logic and the in-flight conversion tracker.
// Both ends run on the same clock.
`timescale 1ns/1ps
interface conv_if;
  logic                          issue;
  logic [adc_ctrl_pkg::CH_W-1:0] issue_ch;
  logic [adc_ctrl_pkg::LAT_W-1:0] lat;
  logic                          busy;
  logic                          done;
  logic [adc_ctrl_pkg::CH_W-1:0] done_ch;
  modport ctrl (output issue, issue_ch, lat, input busy, done, done_ch);
  modport pipe (input issue, issue_ch, lat, output busy, done, done_ch);
endinterface

// File: rtl/conv_pipe.sv
// Tracker of conversions in flight in the pipelined converter stages.
// Assumes issues are spaced so that DEPTH slots cover one latency.
`timescale 1ns/1ps
module conv_pipe #(
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Issue and completion
  conv_if.pipe     cv
);
  localparam int IW = $clog2(DEPTH);

  logic                          busy_q [DEPTH];
  logic [adc_ctrl_pkg::LAT_W-1:0] cnt_q  [DEPTH];
  logic [adc_ctrl_pkg::CH_W-1:0] ch_q   [DEPTH];
  logic [IW-1:0]                 wr_q;
  logic                          done_q;
  logic [adc_ctrl_pkg::CH_W-1:0] done_ch_q;
  logic                          any_busy;

  // ==========================================================================
  // Slots
  // Each slot counts down on its own, so new samples enter while older ones
  // are still in the stages.
  always_ff @(posedge clock) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (rst) begin
        busy_q[i] <= 1'b0;
        cnt_q[i]  <= '0;
        ch_q[i]   <= '0;
      end else if (cv.issue && wr_q == IW'(i)) begin
        busy_q[i] <= 1'b1;
        cnt_q[i]  <= cv.lat - 8'h01;
        ch_q[i]   <= cv.issue_ch;
      end else if (busy_q[i]) begin
        cnt_q[i] <= cnt_q[i] - 8'h01;
        if (cnt_q[i] == 8'h01) begin
          busy_q[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wr_q <= '0;
    end else if (cv.issue) begin
      wr_q <= wr_q + 1'b1;
    end
  end

  // ==========================================================================
  // Completion
  always_ff @(posedge clock) begin
    if (rst) begin
      done_q    <= 1'b0;
      done_ch_q <= '0;
    end else begin
      done_q <= 1'b0;
      for (int i = 0; i < DEPTH; i++) begin
        if (busy_q[i] && cnt_q[i] == 8'h01) begin
          done_q    <= 1'b1;
          done_ch_q <= ch_q[i];
        end
      end
    end
  end

  always_comb begin
    any_busy = 1'b0;
    for (int i = 0; i < DEPTH; i++) begin
      any_busy = any_busy | busy_q[i];
    end
  end

  assign cv.busy    = any_busy;
  assign cv.done    = done_q;
  assign cv.done_ch = done_ch_q;

  slot_free_a: assert property (@(posedge clock) disable iff (rst)
    cv.issue |-> !busy_q[wr_q]) else $error("issue into busy slot");
endmodule

// File: rtl/pipeline_adc_control.sv
// Digital control of a four-channel 12-bit pipelined converter.
// Assumes the converter stages present raw data in the completion cycle.
`timescale 1ns/1ps
module pipeline_adc_control (
  // Clock and reset
  input  wire  logic                              clock,
  input  wire  logic                              rst,
  // Register port
  input  wire  logic [adc_ctrl_pkg::ADDR_W-1:0]   addr,
  input  wire  logic [adc_ctrl_pkg::DATA_W-1:0]   wdata,
  input  wire  logic                              wr_stb,
  input  wire  logic                              rd_stb,
  output logic       [adc_ctrl_pkg::DATA_W-1:0]   rdata,
  // Triggers
  input  wire  logic                              trig_event,
  input  wire  logic                              sync_in,
  output logic                                    sync_out,
  // Converter front end
  output logic                                    smp_strobe,
  output logic       [3:0]                        smp_pos,
  output logic                                    smp_diff,
  output logic       [1:0]                        smp_neg,
  output logic       [2:0]                        smp_gain,
  output logic                                    ref_ext,
  output logic                                    res8,
  input  wire  logic [adc_ctrl_pkg::RAW_W-1:0]    raw_data,
  // Results out
  output logic       [adc_ctrl_pkg::NUM_CH-1:0]   dma_req,
  output logic                                    cmp_event,
  output logic                                    irq
);
  localparam int NC      = adc_ctrl_pkg::NUM_CH;
  localparam int L12     = adc_ctrl_pkg::LAT12_CYC;
  localparam int L8      = adc_ctrl_pkg::LAT8_CYC;
  // Latching the start, clearing the last pending bit and sampling that
  // clear each add one cycle to the sweep itself
  localparam int SWP_HI  = adc_ctrl_pkg::SWEEP_CYC + 3;
  localparam int GAP_MIN = adc_ctrl_pkg::SMP_CYC - 1;

  typedef enum logic {ST_IDLE, ST_GAP} issue_e;
  typedef logic [adc_ctrl_pkg::DATA_W-1:0] word_t;

  conv_if cv ();

  issue_e                            st_q;
  logic [7:0]                        gap_q;
  logic [NC-1:0]                     pend_q;
  logic [NC-1:0]                     pend_d;
  logic [NC-1:0]                     start_req;
  logic [adc_ctrl_pkg::CTRL_W-1:0]   ctrl_q;
  logic [NC-1:0]                     evsel_q;
  logic [2*NC-1:0]                   stat_q;
  logic [2*NC-1:0]                   stat_d;
  logic [2*NC-1:0]                   mask_q;
  logic [2*NC-1:0]                   mask_d;
  logic [adc_ctrl_pkg::RAW_W-1:0]    cmpv_q;
  logic                              cmp_above_q;
  logic [adc_ctrl_pkg::MUX_W-1:0]    mux_q [NC];
  word_t                             res_q [NC];
  logic                              res8_q;
  logic                              issue_q;
  logic [adc_ctrl_pkg::CH_W-1:0]     issue_ch_q;
  logic                              cmp_hit;
  logic [2*NC-1:0]                   set_v;
  logic [2*NC-1:0]                   clr_v;
  logic                              wr_res;
  logic [7:0]                        since_q;

  // ==========================================================================
  // Helpers
  function automatic logic [1:0] lowest(input logic [NC-1:0] m);
    lowest = 2'h0;
    for (int i = NC - 1; i >= 0; i--) begin
      if (m[i]) begin
        lowest = 2'(i);
      end
    end
  endfunction

  function automatic logic [11:0] code(input logic [11:0] raw,
                                       input logic        sgn,
                                       input logic        r8);
    logic [11:0] v;
    v = sgn ? {~raw[11], raw[10:0]} : raw;
    code = r8 ? {v[11:4], 4'h0} : v;
  endfunction

  function automatic word_t fmt(input logic [11:0] c,
                                input logic        r8,
                                input logic        left,
                                input logic        pad1);
    if (r8) begin
      fmt = left ? {c[11:4], {8{pad1}}} : {{8{pad1}}, c[11:4]};
    end else begin
      fmt = left ? {c, {4{pad1}}} : {{4{pad1}}, c};
    end
  endfunction

  function automatic logic is_res(input logic [3:0] a);
    is_res = a[3:2] == adc_ctrl_pkg::A_RES0[3:2];
  endfunction

  // ==========================================================================
  // Configuration registers
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_q      <= adc_ctrl_pkg::CTRL_RST;
      evsel_q     <= '0;
      mask_q      <= '0;
      cmpv_q      <= '0;
      cmp_above_q <= 1'b0;
    end else if (wr_stb) begin
      unique case (addr)
        adc_ctrl_pkg::A_CTRL:  ctrl_q <= wdata[adc_ctrl_pkg::CTRL_W-1:0];
        adc_ctrl_pkg::A_EVSEL: evsel_q <= wdata[NC-1:0];
        adc_ctrl_pkg::A_MASK:  mask_q <= wdata[2*NC-1:0];
        adc_ctrl_pkg::A_CMPV:  cmpv_q <= wdata[11:0];
        adc_ctrl_pkg::A_CMPC:  cmp_above_q <= wdata[0];
        default: ;
      endcase
    end
  end

  // Selections above the last source or gain step are clamped on write
  generate
    for (genvar g = 0; g < NC; g++) begin : g_mux
      always_ff @(posedge clock) begin
        if (rst) begin
          mux_q[g] <= adc_ctrl_pkg::MUX_RST;
        end else if (wr_stb && addr == adc_ctrl_pkg::A_MUX0 + 4'(g)) begin
          mux_q[g][3:0] <= (wdata[3:0] > adc_ctrl_pkg::POS_MAX) ?
                           adc_ctrl_pkg::POS_MAX : wdata[3:0];
          mux_q[g][4]   <= wdata[adc_ctrl_pkg::M_DIFF];
          mux_q[g][6:5] <= wdata[adc_ctrl_pkg::M_NEG_LO +: 2];
          mux_q[g][9:7] <= (wdata[9:7] > adc_ctrl_pkg::GAIN_MAX) ?
                           adc_ctrl_pkg::GAIN_MAX : wdata[9:7];
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Start sources and pending mask
  always_comb begin
    start_req = '0;
    if (wr_stb && addr == adc_ctrl_pkg::A_START) begin
      start_req = start_req | wdata[NC-1:0];
    end
    if (trig_event && ctrl_q[adc_ctrl_pkg::B_EVEN]) begin
      start_req = start_req | evsel_q;
    end
    if (sync_in && ctrl_q[adc_ctrl_pkg::B_SYNC]) begin
      start_req = start_req | evsel_q;
    end
    if (!ctrl_q[adc_ctrl_pkg::B_EN]) begin
      start_req = '0;
    end
    pend_d = pend_q | start_req;
    if (issue_q) begin
      pend_d[issue_ch_q] = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pend_q   <= '0;
      sync_out <= 1'b0;
    end else begin
      pend_q   <= pend_d;
      sync_out <= ctrl_q[adc_ctrl_pkg::B_SYNC] && |start_req &&
                  !sync_in;
    end
  end

  // ==========================================================================
  // Issue sequencer
  // One sample per slot of the sample period; this fixes the rate and the
  // sweep time of four channels, at the cost of no faster bursts.
  always_ff @(posedge clock) begin
    if (rst) begin
      st_q       <= ST_IDLE;
      gap_q      <= '0;
      issue_q    <= 1'b0;
      issue_ch_q <= '0;
    end else begin
      issue_q <= 1'b0;
      unique case (st_q)
        ST_IDLE: begin
          if (|(pend_q & ~(issue_q ? (4'h1 << issue_ch_q) : 4'h0))) begin
            issue_q    <= 1'b1;
            issue_ch_q <= lowest(issue_q ?
                          pend_q & ~(4'h1 << issue_ch_q) : pend_q);
            gap_q      <= 8'(adc_ctrl_pkg::SMP_CYC - 2);
            st_q       <= ST_GAP;
          end
        end
        ST_GAP: begin
          if (gap_q == 8'h00) begin
            st_q <= ST_IDLE;
          end else begin
            gap_q <= gap_q - 8'h01;
          end
        end
      endcase
    end
  end

  // Resolution only switches with the stages empty, so latency stays fixed
  always_ff @(posedge clock) begin
    if (rst) begin
      res8_q <= 1'b0;
    end else if (!cv.busy && !issue_q && pend_q == '0) begin
      res8_q <= ctrl_q[adc_ctrl_pkg::B_RES8];
    end
  end

  assign cv.issue    = issue_q;
  assign cv.issue_ch = issue_ch_q;
  assign cv.lat      = res8_q ? 8'(adc_ctrl_pkg::LAT8_CYC) :
                       8'(adc_ctrl_pkg::LAT12_CYC);

  conv_pipe #(.DEPTH(8)) u_pipe (
    .clock (clock),
    .rst   (rst),
    .cv    (cv.pipe)
  );

  // ==========================================================================
  // Front end drive
  always_ff @(posedge clock) begin
    if (rst) begin
      smp_strobe <= 1'b0;
      smp_pos    <= '0;
      smp_diff   <= 1'b0;
      smp_neg    <= '0;
      smp_gain   <= '0;
      ref_ext    <= 1'b0;
      res8       <= 1'b0;
    end else begin
      smp_strobe <= 1'b0;
      ref_ext    <= ctrl_q[adc_ctrl_pkg::B_REFX];
      res8       <= res8_q;
      if (pend_q != '0 && st_q == ST_IDLE) begin
        smp_strobe <= 1'b1;
        smp_pos    <= mux_q[lowest(pend_q)][3:0];
        smp_diff   <= mux_q[lowest(pend_q)][4];
        smp_neg    <= mux_q[lowest(pend_q)][6:5];
        smp_gain   <= mux_q[lowest(pend_q)][4] ?
                      mux_q[lowest(pend_q)][9:7] : 3'h0;
      end
    end
  end

  // ==========================================================================
  // Results, compare and flags
  assign cmp_hit = cv.done && (cmp_above_q ==
    (ctrl_q[adc_ctrl_pkg::B_SGN] ?
     $signed(code(raw_data, 1'b1, res8_q)) > $signed(cmpv_q) :
     code(raw_data, 1'b0, res8_q) > cmpv_q));

  generate
    for (genvar g = 0; g < NC; g++) begin : g_res
      always_ff @(posedge clock) begin
        if (rst) begin
          res_q[g] <= '0;
        end else if (cv.done && cv.done_ch == 2'(g)) begin
          res_q[g] <= fmt(code(raw_data, ctrl_q[adc_ctrl_pkg::B_SGN],
                       res8_q), res8_q, ctrl_q[adc_ctrl_pkg::B_LEFT],
                       ctrl_q[adc_ctrl_pkg::B_PAD1]);
        end
      end
    end
  endgenerate

  assign wr_res = rd_stb && is_res(addr);

  always_comb begin
    set_v = '0;
    clr_v = '0;
    if (cv.done) begin
      set_v[cv.done_ch]      = 1'b1;
      set_v[NC + cv.done_ch] = cmp_hit;
    end
    if (wr_stb && addr == adc_ctrl_pkg::A_STAT) begin
      clr_v = wdata[2*NC-1:0];
    end
    if (wr_res) begin
      clr_v[addr[1:0]] = 1'b1;
    end
    stat_d = (stat_q & ~clr_v) | set_v;
  end

  // Next mask, so the interrupt follows a mask write in the same cycle
  always_comb begin
    mask_d = mask_q;
    if (wr_stb && addr == adc_ctrl_pkg::A_MASK) begin
      mask_d = wdata[2*NC-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      stat_q    <= '0;
      irq       <= 1'b0;
      dma_req   <= '0;
      cmp_event <= 1'b0;
    end else begin
      stat_q    <= stat_d;
      irq       <= |(stat_d & mask_d);
      dma_req   <= stat_d[NC-1:0] & {NC{ctrl_q[adc_ctrl_pkg::B_DMA]}};
      cmp_event <= cmp_hit;
    end
  end

  // ==========================================================================
  // Read port
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata <= '0;
    end else if (rd_stb) begin
      if (is_res(addr)) begin
        rdata <= res_q[addr[1:0]];
      end else if (addr[3:2] == adc_ctrl_pkg::A_MUX0[3:2]) begin
        rdata <= word_t'(mux_q[addr[1:0]]);
      end else begin
        unique case (addr)
          adc_ctrl_pkg::A_CTRL:  rdata <= word_t'(ctrl_q);
          adc_ctrl_pkg::A_EVSEL: rdata <= word_t'({cv.busy, pend_q, evsel_q});
          adc_ctrl_pkg::A_STAT:  rdata <= word_t'(stat_q);
          adc_ctrl_pkg::A_MASK:  rdata <= word_t'(mask_q);
          adc_ctrl_pkg::A_CMPV:  rdata <= word_t'(cmpv_q);
          adc_ctrl_pkg::A_CMPC:  rdata <= word_t'(cmp_above_q);
          default:               rdata <= '0;
        endcase
      end
    end else begin
      rdata <= '0;
    end
  end

  // ==========================================================================
  // Checks
  always_ff @(posedge clock) begin
    if (rst) begin
      since_q <= 8'hFF;
    end else if (issue_q) begin
      since_q <= 8'h00;
    end else if (since_q != 8'hFF) begin
      since_q <= since_q + 8'h01;
    end
  end

  issue_gap_a: assert property (@(posedge clock) disable iff (rst)
    issue_q |-> since_q >= 8'(GAP_MIN)) else $error("issue too soon");

  issue_order_a: assert property (@(posedge clock) disable iff (rst)
    issue_q |-> ($past(pend_q) & ((4'h1 << issue_ch_q) - 4'h1)) == 4'h0)
    else $error("lower channel skipped");

  sweep_time_a: assert property (@(posedge clock) disable iff (rst)
    (wr_stb && addr == adc_ctrl_pkg::A_START && wdata[3:0] == 4'hF &&
     ctrl_q[adc_ctrl_pkg::B_EN] && pend_q == 4'h0 && st_q == ST_IDLE)
    |-> ##[1:SWP_HI] (pend_q == 4'h0)) else $error("sweep too slow");

  lat12_a: assert property (@(posedge clock) disable iff (rst)
    cv.done && !res8_q |-> $past(issue_q, L12))
    else $error("12-bit latency wrong");

  lat8_a: assert property (@(posedge clock) disable iff (rst)
    cv.done && res8_q |-> $past(issue_q, L8))
    else $error("8-bit latency wrong");

  done_flag_a: assert property (@(posedge clock) disable iff (rst)
    cv.done |=> stat_q[$past(cv.done_ch)])
    else $error("completion flag missing");

  read_clear_a: assert property (@(posedge clock) disable iff (rst)
    wr_res && !(cv.done && cv.done_ch == addr[1:0]) |=>
    !stat_q[$past(addr[1:0])]) else $error("read did not clear");

  irq_level_a: assert property (@(posedge clock) disable iff (rst)
    irq == |(stat_q & mask_q)) else $error("irq level wrong");

  gain_diff_a: assert property (@(posedge clock) disable iff (rst)
    smp_strobe && !smp_diff |-> smp_gain == 3'h0)
    else $error("gain on single ended");

  dma_req_a: assert property (@(posedge clock) disable iff (rst)
    cv.done && ctrl_q[adc_ctrl_pkg::B_DMA] ##1 ctrl_q[adc_ctrl_pkg::B_DMA]
    |-> dma_req[$past(cv.done_ch)]) else $error("no dma request");
endmodule

// File: dv/adc_front_model.sv
// Behavioural converter stages: answer each sample strobe with a raw code.
// Assumes the same clock as the control block and one code per strobe.
`timescale 1ns/1ps
module adc_front_model (
  // Clock
  input  wire logic        clock,
  // Sample request
  input  wire logic        smp_strobe,
  input  wire logic [3:0]  smp_pos,
  input  wire logic        res8,
  // Raw code
  output logic      [11:0] raw_data
);
  // ==========================================================================
  // Answers in flight
  int          cyc = 0;
  int          due_q[$];
  logic [11:0] val_q[$];
  initial raw_data = 12'hA5A;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (smp_strobe) begin
      due_q.push_back(cyc + (res8 ? 99 : 139));
      val_q.push_back({smp_pos, smp_pos ^ 4'hC, 4'h3});
    end
    // Valid only in the completion cycle, so a late sample reads garbage
    if (due_q.size() != 0 && due_q[0] == cyc) begin
      raw_data <= val_q.pop_front();
      void'(due_q.pop_front());
    end else begin
      raw_data <= ~raw_data;
    end
  end
endmodule

// File: dv/tb_top.sv
// Self-checking bench for the converter control block.
// Assumes the behavioural front-end model answers every sample strobe.
`timescale 1ns/1ps
module tb_top;
  // ==========================================================================
  // Signals
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr_stb = 1'b0;
  logic        rd_stb = 1'b0;
  logic        trig_event = 1'b0;
  logic        sync_in = 1'b0;
  logic        sync_out;
  logic        smp_diff;
  logic [1:0]  smp_neg;
  logic [2:0]  smp_gain;
  logic        cmp_event;
  int          n_sync = 0;
  int          n_cmp = 0;
  logic [15:0] rdata;
  logic        smp_strobe;
  logic [3:0]  smp_pos;
  logic        ref_ext;
  logic        res8;
  logic [11:0] raw_data;
  logic [3:0]  dma_req;
  logic        irq;
  int          n_errors = 0;
  int          n_checks = 0;
  initial forever #12.5 clock = ~clock;
  pipeline_adc_control pipeline_adc_control_i (
    .clock(clock), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .trig_event(trig_event), .sync_in(sync_in), .sync_out(sync_out),
    .smp_strobe(smp_strobe), .smp_pos(smp_pos), .smp_diff(smp_diff),
    .smp_neg(smp_neg), .smp_gain(smp_gain), .ref_ext(ref_ext),
    .res8(res8), .raw_data(raw_data), .dma_req(dma_req),
    .cmp_event(cmp_event), .irq(irq));
  // One-cycle pulses are counted here and compared at the end
  always @(posedge clock) begin
    if (sync_out === 1'b1) begin
      n_sync++;
    end
    if (cmp_event === 1'b1) begin
      n_cmp++;
    end
  end
  adc_front_model adc_front_model_i (
    .clock(clock), .smp_strobe(smp_strobe), .smp_pos(smp_pos),
    .res8(res8), .raw_data(raw_data));
  // ==========================================================================
  // Access tasks
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clock);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1;
    check(rdata, e);
  endtask
  // Cycles from first strobe until every channel in m requests transfer
  task automatic run(input logic [3:0] m, input int n);
    int k;
    k = 0;
    while (smp_strobe !== 1'b1 && k < 400) begin
      @(posedge clock);
      #1;
      k++;
    end
    k = 0;
    while ((dma_req & m) !== m && k < 400) begin
      @(posedge clock);
      #1;
      k++;
    end
    check(16'(k), 16'(n));
  endtask
  task automatic finish_test();
    if (n_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ==========================================================================
  // Hang guard, well above the longest sequence
  initial begin
    int t;
    t = 0;
    forever begin
      @(posedge clock);
      t++;
      if (t == 3000) begin
        n_errors++;
        finish_test();
      end
    end
  end
  // ==========================================================================
  // Tests
  initial begin
    logic [3:0] p;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd(adc_ctrl_pkg::A_CTRL, 16'h0000);
    rd(adc_ctrl_pkg::A_MASK, 16'h0000);
    wr(4'h7, 16'hFFFF);
    rd(4'h7, 16'h0000);
    wr(adc_ctrl_pkg::A_MUX0, 16'h03FF);
    rd(adc_ctrl_pkg::A_MUX0, 16'h037B);
    for (int i = 0; i < 4; i++) begin
      wr(4'(adc_ctrl_pkg::A_MUX0 + i), 16'(8 + i));
    end
    wr(adc_ctrl_pkg::A_CMPV, 16'h0000);
    wr(adc_ctrl_pkg::A_CMPC, 16'h0001);
    wr(adc_ctrl_pkg::A_MASK, 16'h00FF);
    wr(adc_ctrl_pkg::A_CTRL, 16'h01C1);
    wr(adc_ctrl_pkg::A_START, 16'h000F);
    run(4'hF, 201);
    rd(adc_ctrl_pkg::A_START, 16'h0000);
    check(16'(ref_ext), 16'h0000);
    rd(adc_ctrl_pkg::A_STAT, 16'h00FF);
    check(16'(irq), 16'h0001);
    wr(adc_ctrl_pkg::A_MASK, 16'h0000);
    rd(adc_ctrl_pkg::A_MASK, 16'h0000);
    check(16'(irq), 16'h0000);
    wr(adc_ctrl_pkg::A_MASK, 16'h00FF);
    for (int i = 0; i < 4; i++) begin
      p = 4'(8 + i);
      rd(4'(adc_ctrl_pkg::A_RES0 + i), {4'h0, p, p ^ 4'hC, 4'h3});
    end
    rd(adc_ctrl_pkg::A_STAT, 16'h00F0);
    wr(adc_ctrl_pkg::A_STAT, 16'h00F0);
    rd(adc_ctrl_pkg::A_STAT, 16'h0000);
    check(16'(irq), 16'h0000);
    // 8-bit, signed, left adjusted with ones, external reference
    wr(adc_ctrl_pkg::A_CTRL, 16'h00FF);
    wr(adc_ctrl_pkg::A_EVSEL, 16'h0004);
    rd(adc_ctrl_pkg::A_CTRL, 16'h00FF);
    check({14'h0000, ref_ext, res8}, 16'h0003);
    @(posedge clock);
    trig_event <= 1'b1;
    @(posedge clock);
    trig_event <= 1'b0;
    run(4'h4, 101);
    rd(adc_ctrl_pkg::A_STAT, 16'h0044);
    rd(4'(adc_ctrl_pkg::A_RES0 + 2), 16'h26FF);
    // Start from the partner instance, differential with gain
    wr(4'(adc_ctrl_pkg::A_MUX0 + 2), 16'h035A);
    wr(adc_ctrl_pkg::A_CTRL, 16'h01FF);
    @(posedge clock);
    sync_in <= 1'b1;
    @(posedge clock);
    sync_in <= 1'b0;
    run(4'h4, 101);
    check(16'({smp_gain, smp_neg, smp_diff, smp_pos}), 16'h035A);
    rd(adc_ctrl_pkg::A_STAT, 16'h0044);
    check(16'(n_sync), 16'h0001);
    check(16'(n_cmp), 16'h0006);
    finish_test();
  end
endmodule
